// file: irpc_pkg.sv
// ****************************************************************
// Register map, field encodings and carriers of the pin block.
// ****************************************************************
package irpc_pkg;

    // ****************************************************************
    // Register indices; the byte address is four times the index.
    // ****************************************************************
    localparam logic [7:0] IRPC_IDX_PIN_A_CTRL = 8'h53;
    localparam logic [7:0] IRPC_IDX_PIN_B_CTRL = 8'h54;
    localparam logic [7:0] IRPC_IDX_HOLD_MODE = 8'h55;
    localparam logic [7:0] IRPC_IDX_ROUTE_A = 8'h56;
    localparam logic [7:0] IRPC_IDX_ROUTE_B = 8'h57;
    localparam logic [7:0] IRPC_IDX_STATUS = 8'h5A;

    // Byte address layout on the bus.
    localparam int IRPC_ADR_W = 10;
    localparam int IRPC_IDX_LSB = 2;
    localparam int IRPC_IDX_W = 8;
    localparam int IRPC_NUM_PINS = 2;

    // Writable bits of each register; the rest read as zero.
    localparam logic [7:0] IRPC_MASK_PIN_CTRL = 8'h1F;
    localparam logic [7:0] IRPC_MASK_ROUTE = 8'hEE;
    localparam logic [7:0] IRPC_RESET_VAL = 8'h00;

    // Status register field positions.
    localparam int IRPC_ST_LATCH_LSB = 0;
    localparam int IRPC_ST_SEEN_LSB = 2;

    // Field encodings.
    localparam logic IRPC_TRIG_LEVEL = 1'b0;
    localparam logic IRPC_TRIG_EDGE = 1'b1;
    localparam logic IRPC_POL_LOW = 1'b0;
    localparam logic IRPC_POL_HIGH = 1'b1;
    localparam logic IRPC_DRIVE_PUSH_PULL = 1'b0;
    localparam logic IRPC_DRIVE_OPEN_DRAIN = 1'b1;
    localparam logic IRPC_HOLD_NONE = 1'b0;
    localparam logic IRPC_HOLD_PERMANENT = 1'b1;

    // Pin control register layout, shared by both pins.
    typedef struct packed {
        logic [2:0] rsvd;
        logic input_en;
        logic output_en;
        logic drive_style;
        logic polarity;
        logic trigger;
    } irpc_pin_ctrl_t;

    // Feature events, laid out like the routing registers.
    typedef struct packed {
        logic error;
        logic any_no_motion;
        logic wakeup;
        logic rsvd4;
        logic wrist_tilt;
        logic activity;
        logic step_counter;
        logic rsvd0;
    } irpc_events_t;

endpackage

// file: irpc_pin.sv
`timescale 1ns/100ps
// ****************************************************************
// One interrupt pin: output drive and input sensing.
// ****************************************************************
module irpc_pin
    import irpc_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input irpc_pin_ctrl_t ctrl,
    input wire logic want,
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe_n,
    output logic in_event
);

    typedef struct packed {
        logic out;
        logic oe_n;
        logic prev_active;
        logic event_q;
    } irpc_pin_state_t;

    irpc_pin_state_t st;
    irpc_pin_state_t next_st;
    logic level;
    logic in_active;

    // Output drive and input sensing; all outputs come from flops.
    always_comb begin
        next_st = st;
        level = (ctrl.polarity == IRPC_POL_HIGH) ? want : ~want;
        if (!ctrl.output_en) begin
            next_st.out = 1'b0;
            next_st.oe_n = 1'b1;
        end else if (ctrl.drive_style == IRPC_DRIVE_OPEN_DRAIN) begin
            // Only the low level is driven; the high level is left to the pull resistor.
            next_st.out = 1'b0;
            next_st.oe_n = level;
        end else begin
            next_st.out = level;
            next_st.oe_n = 1'b0;
        end
        in_active = (pin_in == ctrl.polarity);
        // The previous level follows even while disabled, so enabling gives no false edge.
        next_st.prev_active = in_active;
        next_st.event_q = ctrl.input_en && in_active &&
                          ((ctrl.trigger == IRPC_TRIG_LEVEL) || !st.prev_active);
    end

    // State register.
    always_ff @(posedge clk) begin
        if (srst) begin
            st <= '{out: 1'b0, oe_n: 1'b1, prev_active: 1'b0, event_q: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign pin_out = st.out;
    assign pin_oe_n = st.oe_n;
    assign in_event = st.event_q;

endmodule // irpc_pin

// file: irpc_top.sv
`timescale 1ns/100ps
// How it works
// - Pin input trigger field 0 senses by level, 1 senses by transition.
// - Polarity field 0 drives the pin active low, 1 active high.
// - Drive style field 0 is push-pull, 1 is open drain.
// - The pin is driven only while its output enable bit is set.
// - The pin input reports events only while its input enable bit is set; its level is tracked always.
// - Pin b has its own control register with identical fields.
// - Hold mode bit 0 is non-latched, 1 latched; only writable bit.
// - Pin a routing register bits 1,2,3,5,6,7 route events; 0,4 reserved.
// - Pin b routing register has identical layout, independent of pin a.
// - Routing bit 1 routes the step-counter event.
// - Routing bit 2 routes the activity-class event.
// - Routing bit 3 routes wrist tilt, bit 5 routes wake-up.
// - Routing bit 6 routes any-motion or no-motion detection.
// - Routing bit 7 routes the error event.
// - All control, mode and routing registers reset to zero.
module irpc_top
    import irpc_pkg::*;
#(
    parameter int ADR_W = IRPC_ADR_W
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input irpc_events_t events,
    input wire logic [IRPC_NUM_PINS-1:0] pin_in,
    output logic [IRPC_NUM_PINS-1:0] pin_out,
    output logic [IRPC_NUM_PINS-1:0] pin_oe_n,
    output logic [IRPC_NUM_PINS-1:0] pin_in_event
);

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    if (ADR_W < IRPC_ADR_W) begin : g_bad_adr
        $error("Address bus too narrow for the register map.");
    end

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        irpc_pin_ctrl_t [IRPC_NUM_PINS-1:0] ctrl;
        logic [IRPC_NUM_PINS-1:0][7:0] route;
        logic hold;
        logic [IRPC_NUM_PINS-1:0] latched;
        logic [IRPC_NUM_PINS-1:0] seen;
        logic ack;
        logic [31:0] dat;
    } irpc_top_state_t;

    irpc_top_state_t st;
    irpc_top_state_t next_st;
    logic [IRPC_IDX_W-1:0] idx;
    logic wr;
    logic [7:0] rd;
    logic [IRPC_NUM_PINS-1:0] hit;
    logic [IRPC_NUM_PINS-1:0] want;
    logic [IRPC_NUM_PINS-1:0] in_event;

    assign idx = wb_adr_i[IRPC_IDX_LSB +: IRPC_IDX_W];

    // ****************************************************************
    // Bus slave, register file and interrupt combining
    // ****************************************************************
    // A write lands on the edge where the master sees ack, so it takes effect exactly once.
    always_comb begin
        next_st = st;
        next_st.ack = wb_cyc_i && wb_stb_i && !st.ack;
        wr = wb_cyc_i && wb_stb_i && wb_we_i && st.ack && wb_sel_i[0];
        // Read mux; unmapped indices answer with zero.
        rd = 8'h00;
        if (idx == IRPC_IDX_PIN_A_CTRL) begin
            rd = st.ctrl[0];
        end else if (idx == IRPC_IDX_PIN_B_CTRL) begin
            rd = st.ctrl[1];
        end else if (idx == IRPC_IDX_HOLD_MODE) begin
            rd = {7'h00, st.hold};
        end else if (idx == IRPC_IDX_ROUTE_A) begin
            rd = st.route[0];
        end else if (idx == IRPC_IDX_ROUTE_B) begin
            rd = st.route[1];
        end else if (idx == IRPC_IDX_STATUS) begin
            rd = {4'h0, st.seen, st.latched};
        end
        next_st.dat = (next_st.ack && !wb_we_i) ? {24'h000000, rd} : 32'h00000000;
        // Register writes; reserved bits are masked off.
        if (wr) begin
            if (idx == IRPC_IDX_PIN_A_CTRL) begin
                next_st.ctrl[0] = wb_dat_i[7:0] & IRPC_MASK_PIN_CTRL;
            end else if (idx == IRPC_IDX_PIN_B_CTRL) begin
                next_st.ctrl[1] = wb_dat_i[7:0] & IRPC_MASK_PIN_CTRL;
            end else if (idx == IRPC_IDX_HOLD_MODE) begin
                next_st.hold = wb_dat_i[0];
            end else if (idx == IRPC_IDX_ROUTE_A) begin
                next_st.route[0] = wb_dat_i[7:0] & IRPC_MASK_ROUTE;
            end else if (idx == IRPC_IDX_ROUTE_B) begin
                next_st.route[1] = wb_dat_i[7:0] & IRPC_MASK_ROUTE;
            end
        end
        // Per-pin combining and sticky flags; a set in the clearing cycle wins.
        for (int p = 0; p < IRPC_NUM_PINS; p++) begin
            hit[p] = |(st.route[p] & events & IRPC_MASK_ROUTE);
            want[p] = hit[p] || (st.hold && st.latched[p]);
            if (st.hold == IRPC_HOLD_NONE) begin
                next_st.latched[p] = 1'b0;
            end else begin
                if (wr && idx == IRPC_IDX_STATUS && wb_dat_i[IRPC_ST_LATCH_LSB + p]) begin
                    next_st.latched[p] = 1'b0;
                end
                if (hit[p]) begin
                    next_st.latched[p] = 1'b1;
                end
            end
            if (wr && idx == IRPC_IDX_STATUS && wb_dat_i[IRPC_ST_SEEN_LSB + p]) begin
                next_st.seen[p] = 1'b0;
            end
            if (in_event[p]) begin
                next_st.seen[p] = 1'b1;
            end
        end
    end

    // State register; everything software sees starts at zero.
    always_ff @(posedge clk) begin
        if (srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign wb_ack_o = st.ack;
    assign wb_dat_o = st.dat;
    assign pin_in_event = in_event;

    // ****************************************************************
    // Pin drivers
    // ****************************************************************
    for (genvar g = 0; g < IRPC_NUM_PINS; g++) begin : g_pin
        irpc_pin u_pin (
            .clk(clk),
            .srst(srst),
            .ctrl(st.ctrl[g]),
            .want(want[g]),
            .pin_in(pin_in[g]),
            .pin_out(pin_out[g]),
            .pin_oe_n(pin_oe_n[g]),
            .in_event(in_event[g])
        );
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    // Registers are zero right after reset, and so is the pin drive.
    property p_reset_zero;
        $past(srst) |-> (st.ctrl == '0) && (st.route == '0) && !st.hold && pin_oe_n == '1;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("Registers not zero after reset.");

    // A routed event on an active-high push-pull pin drives it high next cycle.
    property p_route_high_a;
        hit[0] && st.ctrl[0].output_en && st.ctrl[0].polarity && !st.ctrl[0].drive_style
            |=> pin_out[0] && !pin_oe_n[0];
    endproperty
    a_route_high_a: assert property (p_route_high_a) else $error("Routed event did not raise pin a.");

    // Active-low push-pull pin idles high and goes low for a routed event.
    property p_active_low_b;
        st.ctrl[1].output_en && !st.ctrl[1].polarity && !st.ctrl[1].drive_style
            |=> (pin_out[1] == !$past(want[1])) && !pin_oe_n[1];
    endproperty
    a_active_low_b: assert property (p_active_low_b) else $error("Pin b polarity wrong.");

    // Open drain never drives a high level.
    property p_open_drain;
        st.ctrl[0].output_en && st.ctrl[0].drive_style |=> pin_oe_n[0] || !pin_out[0];
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("Open drain pin drove high.");

    // A disabled output leaves the pin undriven.
    property p_out_off;
        !st.ctrl[1].output_en |=> pin_oe_n[1];
    endproperty
    a_out_off: assert property (p_out_off) else $error("Disabled pin b driven.");

    // A disabled input never reports.
    property p_in_off;
        !st.ctrl[0].input_en |=> !in_event[0];
    endproperty
    a_in_off: assert property (p_in_off) else $error("Disabled input reported.");

    // Edge mode reports once for a held level, level mode keeps reporting.
    property p_edge_once;
        st.ctrl[0].input_en && st.ctrl[0].trigger && (pin_in[0] == st.ctrl[0].polarity)
            && ($past(pin_in[0]) == $past(st.ctrl[0].polarity)) |=> !in_event[0];
    endproperty
    a_edge_once: assert property (p_edge_once) else $error("Edge input repeated.");

    property p_level_on;
        st.ctrl[1].input_en && !st.ctrl[1].trigger && (pin_in[1] == st.ctrl[1].polarity) |=> in_event[1];
    endproperty
    a_level_on: assert property (p_level_on) else $error("Level input missed.");

    // Latched mode keeps a routed event asserted with no further event.
    property p_latch_keep;
        st.hold && hit[1] ##1 (st.hold && !wr) |-> want[1];
    endproperty
    a_latch_keep: assert property (p_latch_keep) else $error("Latched event lost.");

    // Non-latched mode holds nothing once the event is gone.
    property p_no_latch;
        !st.hold |=> !st.latched[0] && !st.latched[1];
    endproperty
    a_no_latch: assert property (p_no_latch) else $error("Latch set in non-latched mode.");

    // Reserved routing bits can never be set, so their events never reach a pin.
    property p_route_rsvd;
        wr |=> (st.route[0] & ~IRPC_MASK_ROUTE) == 8'h00 && (st.route[1] & ~IRPC_MASK_ROUTE) == 8'h00;
    endproperty
    a_route_rsvd: assert property (p_route_rsvd) else $error("Reserved routing bit set.");

    // Pin b follows only its own routing.
    property p_b_indep;
        !st.hold && ((st.route[1] & events) == 8'h00) |-> !want[1];
    endproperty
    a_b_indep: assert property (p_b_indep) else $error("Pin b asserted without routed event.");

    // Bus answers one cycle after a request, for one cycle.
    property p_ack;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("Bus ack timing wrong.");

    c_latched: cover property (st.hold && hit[0] ##1 !hit[0] && want[0]);
    c_edge: cover property (st.ctrl[0].trigger && in_event[0]);
    c_both: cover property (hit[0] && hit[1]);
    c_write: cover property (wr && idx == IRPC_IDX_ROUTE_B);

endmodule // irpc_top

// file: irpc_host_model.sv
`timescale 1ns/100ps
// ****************************************************************
// Host side of the two interrupt pins.
// ****************************************************************
module irpc_host_model
    import irpc_pkg::*;
#(
    parameter logic PULL_LEVEL = 1'b1
) (
    input wire logic [IRPC_NUM_PINS-1:0] pin_out,
    input wire logic [IRPC_NUM_PINS-1:0] pin_oe_n,
    input wire logic [IRPC_NUM_PINS-1:0] host_drv,
    input wire logic [IRPC_NUM_PINS-1:0] host_val,
    output logic [IRPC_NUM_PINS-1:0] pin_level
);
    // Resolve each wire; the pull resistor stops a released line from floating.
    always_comb begin
        for (int i = 0; i < IRPC_NUM_PINS; i++) begin
            if (!pin_oe_n[i])
                pin_level[i] = pin_out[i];
            else if (host_drv[i])
                pin_level[i] = host_val[i];
            else
                pin_level[i] = PULL_LEVEL;
        end
    end
endmodule // irpc_host_model

// file: tb_irq_pin_config_and_routing.sv
`timescale 1ns/100ps
// ****************************************************************
// Self-checking bench of the pin configuration and routing block.
// ****************************************************************
module tb_irq_pin_config_and_routing;
    import irpc_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [9:0] wb_adr_i = 10'h000;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    irpc_events_t events = 8'h00;
    logic [1:0] pin_in;
    logic [1:0] pin_out;
    logic [1:0] pin_oe_n;
    logic [1:0] pin_in_event;
    logic [1:0] host_drv = 2'b00;
    logic [1:0] host_val = 2'b00;
    integer errors = 0;
    integer n_tests = 0;
    integer seed = 9969;
    integer regs [5];
    logic [31:0] rd;
    int n;
    localparam logic [7:0] IDX [5] = '{IRPC_IDX_PIN_A_CTRL, IRPC_IDX_PIN_B_CTRL, IRPC_IDX_HOLD_MODE,
                                     IRPC_IDX_ROUTE_A, IRPC_IDX_ROUTE_B};
    localparam logic [7:0] MASK [5] = '{8'h1F, 8'h1F, 8'h01, 8'hEE, 8'hEE};

    // Free-running 20 MHz clock.
    initial begin
        forever #25 clk = ~clk;
    end

    irpc_top #(.ADR_W(10)) dut_u (.clk(clk), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .events(events), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_in_event(pin_in_event));

    irpc_host_model host_u (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .host_drv(host_drv),
        .host_val(host_val), .pin_level(pin_in));

    // ****************************************************************
    // Shared tasks.
    // ****************************************************************
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    // One classic cycle; the request is held until ack is sampled high.
    task automatic wb_xfer(input logic we, input logic [7:0] idx, input logic [7:0] wd);
        int i;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= {24'h0, wd};
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (wb_ack_o !== 1'b1 && i < 20);
        rd = wb_dat_o;
        if (i >= 20) begin
            errors = errors + 1;
            complete_run();
        end
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk);
    endtask

    // Expected {oe_n, out} of a pin from its control byte and the routed OR.
    function automatic logic [31:0] exp_pin(input integer c, input logic act);
        logic lvl;
        lvl = c[1] ? act : ~act;
        if (!c[3])
            return 32'h2;
        if (c[2])
            return {30'h0, lvl, 1'b0};
        return {30'h0, 1'b0, lvl};
    endfunction

    task automatic count_ev(input int p);
        n = 0;
        repeat (6) begin
            @(posedge clk);
            if (pin_in_event[p] === 1'b1)
                n++;
        end
    endtask

    // ****************************************************************
    // Main sequence.
    // ****************************************************************
    initial begin
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        // Reset state, including an unmapped place that ignores writes.
        check({30'h0, pin_oe_n}, 32'h3);
        check({30'h0, pin_out}, 32'h0);
        for (int k = 0; k < 5; k++) begin
            wb_xfer(1'b0, IDX[k], 8'h00);
            check(rd, 32'h0);
        end
        wb_xfer(1'b1, 8'h60, 8'hFF);
        wb_xfer(1'b0, 8'h60, 8'h00);
        check(rd, 32'h0);
        // A write whose low byte lane is not selected stores nothing.
        wb_sel_i <= 4'h0;
        wb_xfer(1'b1, IDX[2], 8'h01);
        wb_sel_i <= 4'hF;
        wb_xfer(1'b0, IDX[2], 8'h00);
        check(rd, 32'h0);
        // Random configurations and events against the model; hold mode stays off.
        repeat (60) begin
            for (int k = 0; k < 5; k++) begin
                regs[k] = (k == 2) ? 0 : ($random(seed) & 8'hFF);
                wb_xfer(1'b1, IDX[k], regs[k][7:0]);
                regs[k] = regs[k] & MASK[k];
            end
            for (int k = 0; k < 5; k++) begin
                wb_xfer(1'b0, IDX[k], 8'h00);
                check(rd, regs[k]);
            end
            events <= 8'($random(seed));
            repeat (3) @(posedge clk);
            for (int p = 0; p < 2; p++) begin
                check({30'h0, pin_oe_n[p], pin_out[p]}, exp_pin(regs[p], |(events & regs[3 + p])));
            end
        end
        // Routing bits 1 to 7 each alone on pin b, push-pull active high.
        wb_xfer(1'b1, IDX[1], 8'h0A);
        for (int b = 1; b < 8; b++) begin
            wb_xfer(1'b1, IDX[4], 8'(1 << b));
            events <= 8'(1 << b);
            repeat (3) @(posedge clk);
            check({31'h0, pin_out[1]}, (b == 4) ? 32'h0 : 32'h1);
        end
        // Latched mode keeps a one-cycle event until hold mode is written zero.
        events <= 8'h00;
        wb_xfer(1'b1, IDX[0], 8'h0A);
        wb_xfer(1'b1, IDX[3], 8'h02);
        wb_xfer(1'b1, IDX[2], 8'h01);
        // Pin b still routes the error event, so it latches the same pulse on its own.
        events <= 8'h82;
        @(posedge clk);
        events <= 8'h00;
        repeat (5) @(posedge clk);
        check({30'h0, pin_oe_n[0], pin_out[0]}, 32'h1);
        check({30'h0, pin_oe_n[1], pin_out[1]}, 32'h1);
        wb_xfer(1'b1, IDX[2], 8'h00);
        repeat (3) @(posedge clk);
        check({30'h0, pin_oe_n[0], pin_out[0]}, 32'h0);
        check({30'h0, pin_oe_n[1], pin_out[1]}, 32'h0);
        // Input sensing on pin a with the output off: level, transition, disabled.
        host_drv <= 2'b01;
        host_val <= 2'b01;
        wb_xfer(1'b1, IDX[0], 8'h12);
        repeat (3) @(posedge clk);
        check({31'h0, pin_in_event[0]}, 32'h1);
        host_val <= 2'b00;
        repeat (3) @(posedge clk);
        check({31'h0, pin_in_event[0]}, 32'h0);
        wb_xfer(1'b1, IDX[0], 8'h13);
        host_val <= 2'b01;
        count_ev(0);
        check(32'(n), 32'h1);
        wb_xfer(1'b1, IDX[0], 8'h03);
        host_val <= 2'b00;
        repeat (3) @(posedge clk);
        host_val <= 2'b01;
        count_ev(0);
        check(32'(n), 32'h0);
        // The sticky input flag of pin a was set above; writing ones clears every status bit.
        wb_xfer(1'b0, IRPC_IDX_STATUS, 8'h00);
        check(rd & 32'h4, 32'h4);
        wb_xfer(1'b1, IRPC_IDX_STATUS, 8'h0F);
        wb_xfer(1'b0, IRPC_IDX_STATUS, 8'h00);
        check(rd, 32'h0);
        complete_run();
    end
endmodule // tb_irq_pin_config_and_routing
